// ### logic/dsli_top.sv
// The address map and the plain strobed port were left to the implementer.
`default_nettype none

// Behaviour
// - Out of reset the input shift register samples serial data on the falling serial clock edge.
// - A control bit moves sampling to the rising edge, with every other edge mirrored.
// - Serial bits enter a 16-bit input shift register, one per active edge.
// - In daisy chain with rising-edge sampling, shifted-out data leaves on the falling edge.
// - A control bit selects a strong or a weak serial output driver.
// - A falling load strobe copies the held input word into the DAC register three system clock edges later.
// - With the load strobe held low in standalone use, the DAC updates on the sixteenth active edge.
// - With the load strobe held low in daisy chain, the DAC updates when frame select rises.
// - Frame select low enables shifting, and standalone use latches the word on the sixteenth edge.
// - Serial output changes on the edge opposite to the sampling edge, and frame select high forces it low at once.
// - After a readback word, the DAC contents leave on the sixteen opposite edges after the next frame's first active edge.
// - A low clear input resets input and DAC registers to zero or midscale as configured.
module dsli_top
  import dsli_pkg::*;
(
  input  wire logic              clock,                 // System clock, 10 MHz
  input  wire logic              rst,                   // Reset, active high; synchronous in the system domain, asynchronous in the link domain
  input  wire logic              serial_clk,            // Serial link clock
  input  wire logic              frame_sync_n,          // Frame select, active low
  input  wire logic              serial_data_in,        // Serial data in
  output logic                   serial_data_out,       // Serial data out
  output logic                   sdo_strong_drive,      // Output driver strength, high = strong
  input  wire logic              load_update_strobe_n,  // Load strobe, active low
  input  wire logic              clear_input_n,         // Clear, active low
  input  wire logic [ADDR_W-1:0] bus_addr,              // Register address
  input  wire logic [BUS_W-1:0]  bus_wdata,             // Register write data
  input  wire logic              bus_write,             // Write strobe
  input  wire logic              bus_read,              // Read strobe
  output logic      [BUS_W-1:0]  bus_rdata,             // Read data, cycle after strobe
  output logic      [DATA_W-1:0] input_code,            // Input register
  output logic      [DATA_W-1:0] dac_code               // DAC register
);

  // ****************************************
  // System-domain state
  // ****************************************
  logic [CTRL_W-1:0]     ctrl_q;
  logic [CTRL_W-1:0]     ctrl_d;
  logic                  cfg_rise_q;
  logic                  cfg_rise_d;
  logic                  cfg_daisy_q;
  logic                  cfg_daisy_d;
  logic [DATA_W-1:0]     input_q;
  logic [DATA_W-1:0]     input_d;
  logic [DATA_W-1:0]     dac_q;
  logic [DATA_W-1:0]     dac_d;
  logic [FRAME_BITS-1:0] last_word_q;
  logic [FRAME_BITS-1:0] last_word_d;
  logic [FRAME_BITS-1:0] rb_word_q;
  logic [FRAME_BITS-1:0] rb_word_d;
  logic                  rb_req_q;
  logic                  rb_req_d;
  dsli_rb_state_t        rb_state_q;
  dsli_rb_state_t        rb_state_d;
  logic [BUS_W-1:0]      rdata_q;
  logic [BUS_W-1:0]      rdata_d;

  // ****************************************
  // Link-domain state
  // ****************************************
  logic                  sample_clk;
  logic [CNT_W-1:0]      bit_cnt_q;
  logic [CNT_W-1:0]      bit_cnt_d;
  logic                  rb_act_q;
  logic                  rb_act_d;
  logic [FRAME_BITS-1:0] shift_q;
  logic [FRAME_BITS-1:0] shift_d;
  logic [FRAME_BITS-1:0] word_q;
  logic [FRAME_BITS-1:0] word_d;
  logic [FRAME_BITS-1:0] out_q;
  logic [FRAME_BITS-1:0] out_d;
  logic                  done_tgl_q;
  logic                  done_tgl_d;
  logic                  rb_ack_q;
  logic                  rb_ack_d;
  logic                  sdo_q;
  logic                  sdo_d;
  logic                  rb_start;

  // ****************************************
  // Crossing wires
  // ****************************************
  logic [SYNC_W-1:0]     sync_lvl;
  logic                  frame_lvl;
  logic                  load_lvl;
  logic                  clear_lvl;
  logic                  done_lvl;
  logic                  ack_lvl;
  logic [EDGE_W-1:0]     edge_rise;
  logic [EDGE_W-1:0]     edge_fall;
  logic                  frame_rise;
  logic                  load_fall;
  logic                  done_event;
  logic                  word_event;
  logic [FRAME_BITS-1:0] word_src;
  logic [DATA_W-1:0]     word_data;
  logic                  word_is_rb;
  logic [DATA_W-1:0]     clear_val;

  function automatic logic [FRAME_BITS-1:0] shift_in(input logic [FRAME_BITS-1:0] cur, input logic bit_in);
    shift_in = {cur[FRAME_BITS-2:0], bit_in};
  endfunction

  // ****************************************
  // Link clock edge selection
  // ****************************************
  // The mux select only moves while the frame is idle, so no clipped edge reaches the shifter
  assign sample_clk = cfg_rise_q ? serial_clk : ~serial_clk;

  assign rb_start = (bit_cnt_q == CNT_ZERO) && (rb_req_q != rb_ack_q);

  // ****************************************
  // Link domain: edge counter
  // ****************************************
  always_comb
  begin
    bit_cnt_d = bit_cnt_q;
    rb_act_d  = rb_act_q;
    if (bit_cnt_q != CNT_FULL)
    begin
      bit_cnt_d = bit_cnt_q + CNT_ONE;
    end
    if (rb_start)
    begin
      rb_act_d = 1'b1;
    end
  end

  // Frame select high ends the count without needing a serial edge
  always_ff @(posedge sample_clk or posedge frame_sync_n or posedge rst)
  begin
    if (frame_sync_n || rst)
    begin
      bit_cnt_q <= CNT_ZERO;
      rb_act_q  <= 1'b0;
    end
    else
    begin
      bit_cnt_q <= bit_cnt_d;
      rb_act_q  <= rb_act_d;
    end
  end

  // ****************************************
  // Link domain: shift, latch and readback
  // ****************************************
  always_comb
  begin
    shift_d    = shift_q;
    word_d     = word_q;
    out_d      = out_q;
    done_tgl_d = done_tgl_q;
    rb_ack_d   = rb_ack_q;
    if (!frame_sync_n)
    begin
      if (cfg_daisy_q || (bit_cnt_q != CNT_FULL))
      begin
        shift_d = shift_in(shift_q, serial_data_in);
      end
      if (!cfg_daisy_q && (bit_cnt_q == CNT_LAST))
      begin
        word_d     = shift_in(shift_q, serial_data_in);
        done_tgl_d = ~done_tgl_q;
      end
      if (rb_start)
      begin
        out_d    = rb_word_q;
        rb_ack_d = ~rb_ack_q;
      end
      else if (rb_act_q)
      begin
        out_d = {out_q[FRAME_BITS-2:0], 1'b0};
      end
    end
  end

  // Toggles persist across frames, so only the system reset clears them
  always_ff @(posedge sample_clk or posedge rst)
  begin
    if (rst)
    begin
      shift_q    <= '0;
      word_q     <= '0;
      out_q      <= '0;
      done_tgl_q <= 1'b0;
      rb_ack_q   <= 1'b0;
    end
    else
    begin
      shift_q    <= shift_d;
      word_q     <= word_d;
      out_q      <= out_d;
      done_tgl_q <= done_tgl_d;
      rb_ack_q   <= rb_ack_d;
    end
  end

  // ****************************************
  // Link domain: serial output on the opposite edge
  // ****************************************
  always_comb
  begin
    sdo_d = rb_act_q ? out_q[FRAME_BITS-1] : shift_q[FRAME_BITS-1];
  end

  always_ff @(negedge sample_clk or posedge frame_sync_n or posedge rst)
  begin
    if (frame_sync_n || rst)
    begin
      sdo_q <= 1'b0;
    end
    else
    begin
      sdo_q <= sdo_d;
    end
  end

  assign serial_data_out  = sdo_q;
  assign sdo_strong_drive = ctrl_q[CTRL_STRONG_BIT];

  // ****************************************
  // Crossings into the system domain
  // ****************************************
  dsli_sync #(
    .WIDTH     (SYNC_W),
    .RESET_VAL (SYNC_RESET)
  ) u_sync (
    .clock    (clock),
    .rst      (rst),
    .async_in ({rb_ack_q, done_tgl_q, clear_input_n, load_update_strobe_n, frame_sync_n}),
    .sync_out (sync_lvl)
  );

  assign frame_lvl = sync_lvl[0];
  assign load_lvl  = sync_lvl[1];
  assign clear_lvl = sync_lvl[2];
  assign done_lvl  = sync_lvl[3];
  assign ack_lvl   = sync_lvl[4];

  dsli_edge #(
    .WIDTH     (EDGE_W),
    .RESET_VAL (EDGE_RESET)
  ) u_edge (
    .clock (clock),
    .rst   (rst),
    .level ({done_lvl, load_lvl, frame_lvl}),
    .rise  (edge_rise),
    .fall  (edge_fall)
  );

  assign frame_rise = edge_rise[0];
  assign load_fall  = edge_fall[1];
  assign done_event = edge_rise[2] | edge_fall[2];

  // Daisy words are read only after frame select rises; the shifter is still then
  assign word_event = cfg_daisy_q ? frame_rise : done_event;
  assign word_src   = cfg_daisy_q ? shift_q : word_q;
  assign word_data  = word_src[DATA_W-1:0];
  assign word_is_rb = (word_src[FRAME_BITS-1:CMD_LSB] == CMD_READBACK);
  assign clear_val  = ctrl_q[CTRL_MID_BIT] ? MID_SCALE : ZERO_SCALE;

  // ****************************************
  // Configuration and register bus
  // ****************************************
  always_comb
  begin
    ctrl_d      = ctrl_q;
    cfg_rise_d  = cfg_rise_q;
    cfg_daisy_d = cfg_daisy_q;
    rdata_d     = '0;
    if (bus_write && (bus_addr == OFF_CTRL))
    begin
      ctrl_d = bus_wdata[CTRL_W-1:0];
    end
    // Link settings follow only while the frame is idle
    if (frame_lvl)
    begin
      cfg_rise_d  = ctrl_q[CTRL_RISE_BIT];
      cfg_daisy_d = ctrl_q[CTRL_DAISY_BIT];
    end
    if (bus_read)
    begin
      case (bus_addr)
        OFF_CTRL:
        begin
          rdata_d[CTRL_W-1:0] = ctrl_q;
        end
        OFF_STATUS:
        begin
          rdata_d[ST_RB_BIT]    = (rb_state_q == DSLI_RB_PEND);
          rdata_d[ST_FRAME_BIT] = ~frame_lvl;
          rdata_d[ST_LOAD_BIT]  = ~load_lvl;
          rdata_d[ST_CLEAR_BIT] = ~clear_lvl;
        end
        OFF_INPUT:
        begin
          rdata_d[DATA_W-1:0] = input_q;
        end
        OFF_DAC:
        begin
          rdata_d[DATA_W-1:0] = dac_q;
        end
        OFF_WORD:
        begin
          rdata_d[FRAME_BITS-1:0] = last_word_q;
        end
        default:
        begin
          rdata_d = '0;
        end
      endcase
    end
  end

  // ****************************************
  // Input, DAC and readback control
  // ****************************************
  always_comb
  begin
    input_d     = input_q;
    dac_d       = dac_q;
    last_word_d = last_word_q;
    rb_word_d   = rb_word_q;
    rb_req_d    = rb_req_q;
    rb_state_d  = rb_state_q;
    if (word_event)
    begin
      last_word_d = word_src;
      if (!word_is_rb)
      begin
        input_d = word_data;
        if (!load_lvl)
        begin
          dac_d = word_data;
        end
      end
    end
    if (load_fall)
    begin
      dac_d = input_d;
    end
    if (!clear_lvl)
    begin
      input_d = clear_val;
      dac_d   = clear_val;
    end
    case (rb_state_q)
      DSLI_RB_IDLE:
      begin
        if (word_event && word_is_rb)
        begin
          rb_word_d  = {{PAD_W{1'b0}}, dac_q};
          rb_req_d   = ~rb_req_q;
          rb_state_d = DSLI_RB_PEND;
        end
      end
      DSLI_RB_PEND:
      begin
        if (ack_lvl == rb_req_q)
        begin
          rb_state_d = DSLI_RB_IDLE;
        end
      end
      default:
      begin
        rb_state_d = DSLI_RB_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      ctrl_q      <= CTRL_RESET;
      cfg_rise_q  <= CTRL_RESET[CTRL_RISE_BIT];
      cfg_daisy_q <= CTRL_RESET[CTRL_DAISY_BIT];
      input_q     <= ZERO_SCALE;
      dac_q       <= ZERO_SCALE;
      last_word_q <= '0;
      rb_word_q   <= '0;
      rb_req_q    <= 1'b0;
      rb_state_q  <= DSLI_RB_IDLE;
      rdata_q     <= '0;
    end
    else
    begin
      ctrl_q      <= ctrl_d;
      cfg_rise_q  <= cfg_rise_d;
      cfg_daisy_q <= cfg_daisy_d;
      input_q     <= input_d;
      dac_q       <= dac_d;
      last_word_q <= last_word_d;
      rb_word_q   <= rb_word_d;
      rb_req_q    <= rb_req_d;
      rb_state_q  <= rb_state_d;
      rdata_q     <= rdata_d;
    end
  end

  assign bus_rdata  = rdata_q;
  assign input_code = input_q;
  assign dac_code   = dac_q;

endmodule

`default_nettype wire

// ### shared/dsli_pkg.sv
`default_nettype none

package dsli_pkg;

  // ****************************************
  // Frame and word layout
  // ****************************************
  localparam int FRAME_BITS = 16;
  localparam int DATA_W     = 12;
  localparam int CMD_W      = 4;
  localparam int CNT_W      = 5;
  localparam int CMD_LSB    = 12;
  localparam int PAD_W      = FRAME_BITS - DATA_W;

  localparam logic [CNT_W-1:0]  CNT_ZERO  = 5'h00;
  localparam logic [CNT_W-1:0]  CNT_LAST  = 5'h0F;
  localparam logic [CNT_W-1:0]  CNT_FULL  = 5'h10;
  localparam logic [CNT_W-1:0]  CNT_ONE   = 5'h01;

  localparam logic [CMD_W-1:0]  CMD_READBACK = 4'hB;

  localparam logic [DATA_W-1:0] ZERO_SCALE = 12'h000;
  localparam logic [DATA_W-1:0] MID_SCALE  = 12'h800;

  // ****************************************
  // Register map
  // ****************************************
  localparam int ADDR_W = 8;
  localparam int BUS_W  = 32;

  localparam logic [ADDR_W-1:0] OFF_CTRL    = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_STATUS  = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_INPUT   = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_DAC     = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_WORD    = 8'h10;

  localparam int CTRL_W          = 4;
  localparam int CTRL_RISE_BIT   = 0;
  localparam int CTRL_STRONG_BIT = 1;
  localparam int CTRL_DAISY_BIT  = 2;
  localparam int CTRL_MID_BIT    = 3;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 4'h0;

  localparam int ST_W          = 4;
  localparam int ST_RB_BIT     = 0;
  localparam int ST_FRAME_BIT  = 1;
  localparam int ST_LOAD_BIT   = 2;
  localparam int ST_CLEAR_BIT  = 3;

  // ****************************************
  // Synchroniser layout and idle levels
  // ****************************************
  localparam int SYNC_W = 5;
  localparam logic [SYNC_W-1:0] SYNC_RESET = 5'h07;
  localparam int EDGE_W = 3;
  localparam logic [EDGE_W-1:0] EDGE_RESET = 3'h3;

  typedef enum logic [0:0]
  {
    DSLI_RB_IDLE = 1'b0,
    DSLI_RB_PEND = 1'b1
  } dsli_rb_state_t;

endpackage

`default_nettype wire

// ### logic/dsli_sync.sv
`default_nettype none

module dsli_sync
  import dsli_pkg::*;
#(
  parameter int               WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
)
(
  input  wire logic             clock,     // System clock
  input  wire logic             rst,       // Synchronous reset
  input  wire logic [WIDTH-1:0] async_in,  // Levels from another domain
  output logic      [WIDTH-1:0] sync_out   // Second-stage levels
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  always_comb
  begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      meta_q <= RESET_VAL;
      sync_q <= RESET_VAL;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;

endmodule

`default_nettype wire

// ### logic/dsli_edge.sv
`default_nettype none

module dsli_edge
  import dsli_pkg::*;
#(
  parameter int               WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
)
(
  input  wire logic             clock,  // System clock
  input  wire logic             rst,    // Synchronous reset
  input  wire logic [WIDTH-1:0] level,  // Already synchronised levels
  output logic      [WIDTH-1:0] rise,   // One-cycle rise pulses
  output logic      [WIDTH-1:0] fall    // One-cycle fall pulses
);

  logic [WIDTH-1:0] prev_q;
  logic [WIDTH-1:0] prev_d;

  always_comb
  begin
    prev_d = level;
    rise   = level & ~prev_q;
    fall   = ~level & prev_q;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      prev_q <= RESET_VAL;
    end
    else
    begin
      prev_q <= prev_d;
    end
  end

endmodule

`default_nettype wire

// ### testbench/dsli_host_model.sv
`default_nettype none

module dsli_host_model
(
  output var logic  serial_clk,      // Link clock, idles low
  output var logic  frame_sync_n,    // Frame select, active low
  output var logic  serial_data_in,  // Data to the device
  input  wire logic serial_data_out  // Data from the device
);
  timeunit 1ns;
  timeprecision 1ns;

  initial
  begin
    serial_clk     = 1'b0;
    frame_sync_n   = 1'b1;
    serial_data_in = 1'b0;
  end

  // ****************************************
  // Frame transfer
  // ****************************************
  // Data flips between edges, so a device sampling on the wrong edge sees the inverse
  task automatic xfer(input logic rise, input int n, input logic [31:0] w, output logic [31:0] cap);
    cap = '0;
    #13;
    frame_sync_n = 1'b0;
    #40;
    for (int i = n - 1; i >= 0; i--)
    begin
      if (!rise) serial_clk = 1'b1;
      #20 serial_data_in = w[i];
      #40 cap = {cap[30:0], serial_data_out};
      serial_clk = rise;
      #40 serial_data_in = ~w[i];
      #20 if (rise) serial_clk = 1'b0;
      #40;
    end
    frame_sync_n = 1'b1;
    #2000;
  endtask
endmodule

`default_nettype wire

// ### testbench/dsli_top_props.sv
`default_nettype none

module dsli_top_props
  import dsli_pkg::*;
(
  input wire logic              clock,                 // System clock
  input wire logic              rst,                   // Synchronous reset
  input wire logic              frame_sync_n,          // Frame select
  input wire logic              serial_data_out,       // Serial data out
  input wire logic              sdo_strong_drive,      // Driver strength
  input wire logic              load_update_strobe_n,  // Load strobe
  input wire logic              clear_input_n,         // Clear
  input wire logic [ADDR_W-1:0] bus_addr,              // Address
  input wire logic [BUS_W-1:0]  bus_wdata,             // Write data
  input wire logic              bus_write,             // Write strobe
  input wire logic              bus_read,              // Read strobe
  input wire logic [BUS_W-1:0]  bus_rdata,             // Read data
  input wire logic [DATA_W-1:0] input_code,            // Input register
  input wire logic [DATA_W-1:0] dac_code               // DAC register
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  // ****************************************
  // Properties
  // ****************************************
  property p_strong_map;
    logic v;
    (bus_write && bus_addr == OFF_CTRL, v = bus_wdata[CTRL_STRONG_BIT]) |=> sdo_strong_drive == v;
  endproperty
  a_strong_map: assert property (p_strong_map)
    else $error("driver strength not taken from control write");

  property p_strong_hold;
    !(bus_write && bus_addr == OFF_CTRL) |=> $stable(sdo_strong_drive);
  endproperty
  a_strong_hold: assert property (p_strong_hold)
    else $error("driver strength moved without a write");

  property p_rdata_ctrl;
    bus_read && bus_addr == OFF_CTRL |=>
      bus_rdata[CTRL_STRONG_BIT] == sdo_strong_drive && bus_rdata[BUS_W-1:CTRL_W] == '0;
  endproperty
  a_rdata_ctrl: assert property (p_rdata_ctrl)
    else $error("control read disagrees with driver strength");

  property p_dac_read;
    bus_read && bus_addr == OFF_DAC |=> bus_rdata == {{(BUS_W-DATA_W){1'b0}}, $past(dac_code)};
  endproperty
  a_dac_read: assert property (p_dac_read)
    else $error("DAC read value wrong");

  // Synchronisers take up to three cycles, hence the long windows
  property p_clear_val;
    (!clear_input_n)[*5] |-> input_code == dac_code && (input_code == ZERO_SCALE || input_code == MID_SCALE);
  endproperty
  a_clear_val: assert property (p_clear_val)
    else $error("clear did not force a clear value");

  property p_clear_hold;
    (!clear_input_n && !bus_write)[*6] |-> $stable(input_code);
  endproperty
  a_clear_hold: assert property (p_clear_hold)
    else $error("input register moved under clear");

  property p_load_copy;
    (!load_update_strobe_n && clear_input_n)[*6] |-> dac_code == input_code;
  endproperty
  a_load_copy: assert property (p_load_copy)
    else $error("DAC does not follow input with load low");

  property p_dac_hold;
    (load_update_strobe_n && clear_input_n)[*5] |=> $stable(dac_code);
  endproperty
  a_dac_hold: assert property (p_dac_hold)
    else $error("DAC moved with load high");

  property p_input_idle;
    (frame_sync_n && clear_input_n)[*8] |=> $stable(input_code);
  endproperty
  a_input_idle: assert property (p_input_idle)
    else $error("input register moved outside a frame");

  property p_sdo_idle;
    frame_sync_n[*2] |-> !serial_data_out;
  endproperty
  a_sdo_idle: assert property (p_sdo_idle)
    else $error("serial out active while frame idle");

  c_load_fall: cover property ($fell(load_update_strobe_n));
  c_clear: cover property ((!clear_input_n)[*5]);
  c_frame_end: cover property ($rose(frame_sync_n));
  c_dac_read: cover property (bus_read && bus_addr == OFF_DAC);
endmodule

bind dsli_top dsli_top_props u_props
(
  .clock(clock), .rst(rst), .frame_sync_n(frame_sync_n), .serial_data_out(serial_data_out),
  .sdo_strong_drive(sdo_strong_drive), .load_update_strobe_n(load_update_strobe_n),
  .clear_input_n(clear_input_n), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_write(bus_write),
  .bus_read(bus_read), .bus_rdata(bus_rdata), .input_code(input_code), .dac_code(dac_code)
);

`default_nettype wire

// ### testbench/tb_top.sv
`default_nettype none

module tb_top
  import dsli_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  `define CHK(nm, e, g) check(nm, 32'(e), 32'(g))

  logic              clock, rst, serial_clk, frame_sync_n, serial_data_in, serial_data_out;
  logic              sdo_strong_drive, load_update_strobe_n, clear_input_n, bus_write, bus_read;
  logic [ADDR_W-1:0] bus_addr;
  logic [BUS_W-1:0]  bus_wdata, bus_rdata, d, cap;
  logic [DATA_W-1:0] input_code, dac_code;
  int                bad_count = 0;
  int                cmp_count = 0;
  int                cyc = 0;

  dsli_top uut
  (
    .clock(clock), .rst(rst), .serial_clk(serial_clk), .frame_sync_n(frame_sync_n),
    .serial_data_in(serial_data_in), .serial_data_out(serial_data_out), .sdo_strong_drive(sdo_strong_drive),
    .load_update_strobe_n(load_update_strobe_n), .clear_input_n(clear_input_n), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_write(bus_write), .bus_read(bus_read), .bus_rdata(bus_rdata),
    .input_code(input_code), .dac_code(dac_code)
  );

  dsli_host_model u_host
  (
    .serial_clk(serial_clk), .frame_sync_n(frame_sync_n), .serial_data_in(serial_data_in),
    .serial_data_out(serial_data_out)
  );

  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // Whole run needs well under a thousand cycles
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      bad_count++;
      wrap_up();
    end
  end

  // ****************************************
  // Bus and reporting tasks
  // ****************************************
  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      bad_count++;
      $display("[FAIL] %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [BUS_W-1:0] v);
    @(posedge clock);
    bus_write <= 1'b1;
    bus_addr  <= a;
    bus_wdata <= v;
    @(posedge clock);
    bus_write <= 1'b0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [BUS_W-1:0] v);
    @(posedge clock);
    bus_read <= 1'b1;
    bus_addr <= a;
    @(posedge clock);
    bus_read <= 1'b0;
    #1 v = bus_rdata;
  endtask

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ****************************************
  // Test sequence
  // ****************************************
  initial
  begin
    rst                  = 1'b1;
    load_update_strobe_n = 1'b1;
    clear_input_n        = 1'b1;
    bus_write            = 1'b0;
    bus_read             = 1'b0;
    bus_addr             = '0;
    bus_wdata            = '0;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    repeat (4) @(posedge clock);
    rd(OFF_CTRL, d);
    `CHK("ctrl_reset", CTRL_RESET, d);
    rd(OFF_STATUS, d);
    `CHK("status_idle", 0, d);
    rd(8'h24, d);
    `CHK("unmapped", 0, d);
    wr(OFF_CTRL, 32'h2);
    #1 `CHK("strong", 1, sdo_strong_drive);
    rd(OFF_CTRL, d);
    `CHK("ctrl", 32'h2, d);
    wr(OFF_CTRL, 32'h0);
    #1 `CHK("weak", 0, sdo_strong_drive);
    $display("done: registers");
    @(posedge clock);
    load_update_strobe_n <= 1'b0;
    u_host.xfer(1'b0, 16, 32'h0ABC, cap);
    `CHK("input", 12'hABC, input_code);
    `CHK("dac", 12'hABC, dac_code);
    // Four extra edges past the word must be ignored
    u_host.xfer(1'b0, 20, {12'h0, 16'h0123, 4'hF}, cap);
    `CHK("input", 12'h123, input_code);
    `CHK("dac", 12'h123, dac_code);
    rd(OFF_DAC, d);
    `CHK("dac_reg", 12'h123, d);
    $display("done: standalone");
    @(posedge clock);
    load_update_strobe_n <= 1'b1;
    u_host.xfer(1'b0, 16, 32'h0456, cap);
    `CHK("input", 12'h456, input_code);
    `CHK("dac_held", 12'h123, dac_code);
    @(posedge clock);
    load_update_strobe_n <= 1'b0;
    repeat (6) @(posedge clock);
    load_update_strobe_n <= 1'b1;
    #1 `CHK("dac_load", 12'h456, dac_code);
    $display("done: load strobe");
    u_host.xfer(1'b0, 16, 32'hB000, cap);
    `CHK("input_rb", 12'h456, input_code);
    rd(OFF_STATUS, d);
    `CHK("rb_pending", 32'h1, d);
    u_host.xfer(1'b0, 17, {15'h0, 16'h0789, 1'b0}, cap);
    `CHK("readback", 16'h0456, cap[15:0]);
    `CHK("input", 12'h789, input_code);
    rd(OFF_STATUS, d);
    `CHK("rb_done", 0, d);
    rd(OFF_WORD, d);
    `CHK("last_word", 16'h0789, d);
    rd(OFF_INPUT, d);
    `CHK("input_reg", 12'h789, d);
    $display("done: readback");
    wr(OFF_CTRL, 32'h1);
    u_host.xfer(1'b1, 16, 32'h0321, cap);
    `CHK("input_rise", 12'h321, input_code);
    $display("done: rising edge");
    wr(OFF_CTRL, 32'h5);
    @(posedge clock);
    load_update_strobe_n <= 1'b0;
    u_host.xfer(1'b1, 32, {16'h0AAA, 16'h0555}, cap);
    `CHK("chain_out", 16'h0AAA, cap[15:0]);
    `CHK("input", 12'h555, input_code);
    `CHK("dac", 12'h555, dac_code);
    rd(OFF_STATUS, d);
    `CHK("status_load", 32'h4, d);
    $display("done: daisy chain");
    for (int m = 0; m < 2; m++)
    begin
      wr(OFF_CTRL, m ? 32'h8 : 32'h0);
      @(posedge clock);
      clear_input_n <= 1'b0;
      repeat (6) @(posedge clock);
      clear_input_n <= 1'b1;
      #1 `CHK("clr_input", m ? MID_SCALE : ZERO_SCALE, input_code);
      `CHK("clr_dac", m ? MID_SCALE : ZERO_SCALE, dac_code);
    end
    $display("done: clear");
    wrap_up();
  end
endmodule

`default_nettype wire
